// ---- hw/tpr_regs.sv ----
// Contract
// - phase offset is signed n, pi*n/128
// - test mode forces sample phase from bits 4:0
// - test mode forces strobe from bit 5
// - test mode forces level detect from bit 6
// - test mode forces I data bits 16:7
// - test mode forces data valid bit 17
// - test mode forces LO marker bit 18
// - test mode forces Q data bits 28:19
// - test enable is address 4 bit 3
// - write to address 9 snapshots AGC accumulator
// - snapshot stays stable for control readback
// - sample phase is selectable 5-of-8 slice
`timescale 1ns/1ns
`default_nettype none
module tpr_regs
  import tpr_pkg::*;
(
  input  wire logic        ref_clk,          // sample clock
  input  wire logic        rst_n,            // synchronous reset, active low
  input  wire logic        ctrl_wr,          // one-cycle write strobe
  input  wire logic [3:0]  ctrl_addr,        // destination address
  input  wire logic [31:0] ctrl_wdata,       // assembled write word
  input  wire logic [31:0] config_word,      // contents of address 4 register
  input  wire logic [7:0]  agc_accum,        // live AGC loop-filter accumulator
  input  wire logic [31:0] resamp_phase,     // re-sampler phase accumulator
  input  wire tpr_pins_type normal_pins,     // datapath pin values
  output logic [7:0]       carrier_phase,    // two's complement phase offset
  output logic signed [15:0] phase_pi_frac,  // offset scaled to pi/32768 units
  output logic [7:0]       agc_snapshot,     // held value for control readback
  output logic [7:0]       control_data_bus, // readback byte toward the port
  output logic [4:0]       sample_phase_out, // sample phase pins
  output logic             sample_strobe_out,   // sample strobe pin
  output logic             level_detect_out,    // input level detect pin
  output logic [9:0]       inphase_data_out,    // I data pins
  output logic [9:0]       quadrature_data_out, // Q data pins
  output logic             output_data_valid,   // data ready pin
  output logic             lo_marker_out        // LO marker pin
);

  logic [31:0]  carrier_phase_offset;
  logic [31:0]  output_force_test;
  logic [7:0]   agc_accumulator_snapshot;
  logic         test_en;
  logic [31:0]  next_phase;
  logic [31:0]  next_test;
  logic [7:0]   next_agc;
  logic         next_test_en;
  tpr_pins_type forced;
  tpr_pins_type normal_sel;
  tpr_pins_type next_pins;
  tpr_pins_type pins;

  always_comb begin
    next_phase   = carrier_phase_offset;
    next_test    = output_force_test;
    next_agc     = agc_accumulator_snapshot;
    next_test_en = config_word[TPR_CFG_TEST_EN_BIT];
    if (ctrl_wr) begin
      case (ctrl_addr)
        TPR_ADDR_PHASE: next_phase = {24'h000000, ctrl_wdata[TPR_PHASE_MSB:0]};
        TPR_ADDR_TEST:  next_test  = {3'h0, ctrl_wdata[TPR_TEST_MSB:0]};
        // data written is ignored, only the write matters
        TPR_ADDR_AGC:   next_agc   = agc_accum;
        default:        next_phase = carrier_phase_offset;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      carrier_phase_offset     <= TPR_PHASE_RST;
      output_force_test        <= TPR_TEST_RST;
      agc_accumulator_snapshot <= TPR_AGC_RST;
      test_en                  <= TPR_TEST_EN_RST;
    end else begin
      carrier_phase_offset     <= next_phase;
      output_force_test        <= next_test;
      agc_accumulator_snapshot <= next_agc;
      test_en                  <= next_test_en;
    end
  end

  assign carrier_phase = carrier_phase_offset[TPR_PHASE_MSB:0];
  // pi*n/128 expressed in pi/32768 units keeps the scaling exact
  assign phase_pi_frac = 16'(signed'(carrier_phase) * (32768 / TPR_PHASE_DIV));
  assign agc_snapshot  = agc_accumulator_snapshot;
  assign control_data_bus = agc_accumulator_snapshot;

  always_comb begin
    forced.sample_phase  = output_force_test[TPR_SPH_LSB +: 5];
    forced.sample_strobe = output_force_test[TPR_STRB_BIT];
    forced.level_detect  = output_force_test[TPR_LVL_BIT];
    forced.i_data        = output_force_test[TPR_I_LSB +: 10];
    forced.data_valid    = output_force_test[TPR_VALID_BIT];
    forced.lo_marker     = output_force_test[TPR_LO_BIT];
    forced.q_data        = output_force_test[TPR_Q_LSB +: 10];
    normal_sel = normal_pins;
    // slice select sits in config bits 12:11 and picks within bits 31:24
    case (config_word[TPR_SPH_SEL_LSB +: 2])
      2'h0:    normal_sel.sample_phase = resamp_phase[28:24];
      2'h1:    normal_sel.sample_phase = resamp_phase[29:25];
      2'h2:    normal_sel.sample_phase = resamp_phase[30:26];
      2'h3:    normal_sel.sample_phase = resamp_phase[31:27];
      default: normal_sel.sample_phase = resamp_phase[28:24];
    endcase
    next_pins = test_en ? forced : normal_sel;
  end

  // pins registered so every data output comes from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign sample_phase_out    = pins.sample_phase;
  assign sample_strobe_out   = pins.sample_strobe;
  assign level_detect_out    = pins.level_detect;
  assign inphase_data_out    = pins.i_data;
  assign quadrature_data_out = pins.q_data;
  assign output_data_valid   = pins.data_valid;
  assign lo_marker_out       = pins.lo_marker;

  force_sph_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> sample_phase_out == $past(output_force_test[4:0]))
    else $error("sample phase not forced");
  force_strb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> sample_strobe_out == $past(output_force_test[5]))
    else $error("strobe not forced");
  force_lvl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> level_detect_out == $past(output_force_test[6]))
    else $error("level detect not forced");
  force_i_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> inphase_data_out == $past(output_force_test[16:7]))
    else $error("I data not forced");
  force_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> output_data_valid == $past(output_force_test[17]))
    else $error("data valid not forced");
  force_lo_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> lo_marker_out == $past(output_force_test[18]))
    else $error("LO marker not forced");
  force_q_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_en |=> quadrature_data_out == $past(output_force_test[28:19]))
    else $error("Q data not forced");
  test_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 test_en == $past(config_word[3]))
    else $error("test enable not from bit 3");
  agc_snap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_wr && ctrl_addr == 4'h9) |=> agc_snapshot == $past(agc_accum))
    else $error("agc snapshot missed");
  agc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(ctrl_wr && ctrl_addr == 4'h9) |=> $stable(agc_snapshot))
    else $error("agc snapshot changed");
  normal_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !test_en |=> inphase_data_out == $past(normal_pins.i_data)
      && lo_marker_out == $past(normal_pins.lo_marker))
    else $error("normal value not passed");
  sph_slice_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!test_en && config_word[12:11] == 2'h3) |=> sample_phase_out == $past(resamp_phase[31:27]))
    else $error("phase slice wrong");
  normal_rest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !test_en |=> quadrature_data_out == $past(normal_pins.q_data)
      && sample_strobe_out == $past(normal_pins.sample_strobe)
      && level_detect_out == $past(normal_pins.level_detect)
      && output_data_valid == $past(normal_pins.data_valid))
    else $error("normal value not passed");
  sph_slice0_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!test_en && config_word[12:11] == 2'h0) |=> sample_phase_out == $past(resamp_phase[28:24]))
    else $error("phase slice wrong");
  sph_slice1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!test_en && config_word[12:11] == 2'h1) |=> sample_phase_out == $past(resamp_phase[29:25]))
    else $error("phase slice wrong");
  sph_slice2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!test_en && config_word[12:11] == 2'h2) |=> sample_phase_out == $past(resamp_phase[30:26]))
    else $error("phase slice wrong");
  phase_scale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_wr && ctrl_addr == 4'h7 && ctrl_wdata[7:0] == 8'h80) |=> phase_pi_frac == 16'h8000)
    else $error("phase scaling wrong");

endmodule : tpr_regs
`default_nettype wire

// ---- hw/tpr_pkg.sv ----
package tpr_pkg;

  // destination addresses on the control port
  localparam logic [3:0] TPR_ADDR_CONFIG = 4'h4;
  localparam logic [3:0] TPR_ADDR_PHASE  = 4'h7;
  localparam logic [3:0] TPR_ADDR_TEST   = 4'h8;
  localparam logic [3:0] TPR_ADDR_AGC    = 4'h9;

  // field positions
  localparam int TPR_CFG_TEST_EN_BIT = 3;
  localparam int TPR_PHASE_MSB       = 7;
  localparam int TPR_SPH_LSB         = 0;
  localparam int TPR_STRB_BIT        = 5;
  localparam int TPR_LVL_BIT         = 6;
  localparam int TPR_I_LSB           = 7;
  localparam int TPR_VALID_BIT       = 17;
  localparam int TPR_LO_BIT          = 18;
  localparam int TPR_Q_LSB           = 19;
  localparam int TPR_TEST_MSB        = 28;
  localparam int TPR_SPH_SEL_LSB     = 11;
  localparam int TPR_PHASE_DIV       = 128;

  // reset values
  localparam logic [31:0] TPR_PHASE_RST  = 32'h0000_0000;
  localparam logic [31:0] TPR_TEST_RST   = 32'h0000_0000;
  localparam logic [7:0]  TPR_AGC_RST    = 8'h00;
  localparam logic        TPR_TEST_EN_RST = 1'b0;

  // one bundle for every pin that the output_force_test can force
  typedef struct packed {
    logic       lo_marker;
    logic       data_valid;
    logic [9:0] q_data;
    logic [9:0] i_data;
    logic       level_detect;
    logic       sample_strobe;
    logic [4:0] sample_phase;
  } tpr_pins_type;

endpackage : tpr_pkg

// ---- bench/tpr_cpu.sv ----
`timescale 1ns/1ns
`default_nettype none
module tpr_cpu
  import tpr_pkg::*;
(
  input  wire logic        ref_clk,   // sample clock
  output logic             ctrl_wr,   // write strobe
  output logic [3:0]       ctrl_addr, // destination address
  output logic [31:0]      ctrl_wdata // write word
);
  initial begin
    ctrl_wr    = 1'b0;
    ctrl_addr  = 4'h0;
    ctrl_wdata = 32'h0;
  end
  // lines scrambled after release so stale data is never mistaken for a write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    ctrl_wr    = 1'b1;
    ctrl_addr  = a;
    ctrl_wdata = d;
    @(negedge ref_clk);
    ctrl_wr    = 1'b0;
    ctrl_addr  = ~a;
    ctrl_wdata = ~d;
  endtask : wr
endmodule : tpr_cpu
`default_nettype wire

// ---- bench/tuner_phase_test_agc_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tuner_phase_test_agc_regs_tb
  import tpr_pkg::*;
;
  logic ref_clk, rst_n, ctrl_wr, s_strb, s_lvl, s_valid, s_lo;
  logic [3:0] ctrl_addr;
  logic [31:0] ctrl_wdata, config_word, resamp_phase;
  logic [7:0] agc_accum, carrier_phase, agc_snapshot, control_data_bus;
  logic signed [15:0] phase_pi_frac;
  logic [4:0] s_sph;
  logic [9:0] s_i, s_q;
  tpr_pins_type normal_pins, pins_seen;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] pats [3] = '{32'hffff_ffff, 32'h1234_5678, 32'h0dcb_a987};
  logic [7:0] phs [4] = '{8'h80, 8'h7f, 8'h01, 8'hff};
  assign pins_seen = {s_lo, s_valid, s_q, s_i, s_lvl, s_strb, s_sph};
  tpr_cpu cpu (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
    .ctrl_wdata(ctrl_wdata));
  tpr_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
    .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .config_word(config_word),
    .agc_accum(agc_accum), .resamp_phase(resamp_phase), .normal_pins(normal_pins),
    .carrier_phase(carrier_phase), .phase_pi_frac(phase_pi_frac),
    .agc_snapshot(agc_snapshot), .control_data_bus(control_data_bus),
    .sample_phase_out(s_sph), .sample_strobe_out(s_strb), .level_detect_out(s_lvl),
    .inphase_data_out(s_i), .quadrature_data_out(s_q), .output_data_valid(s_valid),
    .lo_marker_out(s_lo));
  function automatic tpr_pins_type fx(input logic [31:0] w);
    return {w[18], w[17], w[28:19], w[16:7], w[6], w[5], w[4:0]};
  endfunction : fx
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  initial begin
    rst_n       = 1'b0;
    config_word = 32'h0;
    agc_accum   = 8'h00;
    normal_pins = 29'h1b3c_5a69;
    // slice 0 (bits 28:24) matches the datapath phase 5'h09, slice 3 gives 5'h15
    resamp_phase = 32'ha900_0000;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    chk(carrier_phase, 32'h0);
    chk(agc_snapshot, 32'h0);
    repeat (3) @(negedge ref_clk);
    chk(pins_seen, normal_pins);
    cpu.wr(TPR_ADDR_TEST, 32'hffff_ffff);
    repeat (3) @(negedge ref_clk);
    chk(pins_seen, normal_pins);
    config_word = 32'h0000_0008;
    foreach (pats[k]) begin
      cpu.wr(TPR_ADDR_TEST, pats[k]);
      repeat (3) @(negedge ref_clk);
      chk(pins_seen, fx(pats[k]));
    end
    config_word = 32'h0;
    repeat (3) @(negedge ref_clk);
    chk(pins_seen, normal_pins);
    config_word = 32'h0000_1800;
    repeat (3) @(negedge ref_clk);
    chk(s_sph, 32'h15);
    config_word = 32'h0;
    repeat (3) @(negedge ref_clk);
    chk(s_sph, 32'h09);
    foreach (phs[k]) begin
      cpu.wr(TPR_ADDR_PHASE, {24'hffffff, phs[k]});
      chk(carrier_phase, phs[k]);
      chk($unsigned(phase_pi_frac), {phs[k], 8'h00});
    end
    cpu.wr(4'h3, 32'h0);
    chk(carrier_phase, 32'hff);
    // accumulator moves right after the capture edge
    agc_accum = 8'h5a;
    cpu.wr(TPR_ADDR_AGC, 32'hffff_ffa5);
    agc_accum = 8'hc3;
    repeat (2) @(negedge ref_clk);
    chk(agc_snapshot, 32'h5a);
    chk(control_data_bus, 32'h5a);
    cpu.wr(TPR_ADDR_AGC, 32'h0);
    agc_accum = 8'h11;
    @(negedge ref_clk);
    chk(control_data_bus, 32'hc3);
    final_report;
  end
endmodule : tuner_phase_test_agc_regs_tb
`default_nettype wire
